// ==== inc/mpm_defines.vh ====
// Register map, field positions and reset values for the PHY management block
`ifndef MPM_DEFINES_VH
`define MPM_DEFINES_VH
`define MPM_ADDR_CTRL_OFS   12'h014
`define MPM_DATA_OFS        12'h018
`define MPM_FLOW_CTRL_OFS   12'h01c
`define MPM_PHY_SEL_HI      15
`define MPM_PHY_SEL_LO      11
`define MPM_REG_IDX_HI      10
`define MPM_REG_IDX_LO      6
`define MPM_WRITE_SEL_BIT   1
`define MPM_BUSY_BIT        0
`define MPM_PAUSE_HI        31
`define MPM_PAUSE_LO        16
`define MPM_HONOR_BIT       1
`define MPM_SEND_BIT        0
`define MPM_PHY_SEL_RST     5'h0b
`define MPM_REG_IDX_RST     5'h0b
`define MPM_PAUSE_RST       16'h0050
`define MPM_HONOR_RST       1'b1
`define MPM_MDC_HALF_NS     200
`define MPM_CLK_NS          10
`define MPM_MDC_HALF_CYC    (`MPM_MDC_HALF_NS / `MPM_CLK_NS)
`define MPM_FRAME_BITS      64
`define MPM_TA_BIT          46
`endif

// ==== core/mpm_mgmt.v ====
// PHY management command unit with pause-time and pause-request control
//
// Implementation choice: the APB interface to the registers.
`include "mpm_defines.vh"
`default_nettype none
module mpm_mgmt
#(
    parameter MDC_HALF_CYC = `MPM_MDC_HALF_CYC,
    parameter FRAME_BITS   = `MPM_FRAME_BITS
)
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         mdc,
    output reg         mdio_out,
    output reg         mdio_oe_n,
    input  wire        mdio_in,
    output reg         pause_start,
    output reg  [15:0] pause_time,
    output reg         pause_honor,
    input  wire        pause_done
);
    // One-hot frame engine states
    localparam ST_IDLE = 3'b001;
    localparam ST_RUN  = 3'b010;
    localparam ST_DONE = 3'b100;

    // Sized copies of the frame timing counts
    localparam [7:0] HALF_LAST = MDC_HALF_CYC - 1;
    localparam [6:0] LAST_BIT  = FRAME_BITS;
    localparam [6:0] TA_FIRST  = `MPM_TA_BIT;
    localparam [6:0] RD_FIRST  = `MPM_TA_BIT + 2;

    // Register fields and frame engine state
    reg [4:0]  phy_select_field;
    reg [4:0]  phy_reg_index_field;
    reg        mgmt_write_select;
    reg        mgmt_busy_flag;
    reg [15:0] mgmt_data_field;
    reg        pause_send_request;
    reg [2:0]  state;
    reg [7:0]  div_cnt;
    reg [6:0]  bit_cnt;
    reg [63:0] shifter;
    reg [15:0] rd_shift;
    reg        mdio_s1;
    reg        mdio_s2;
    reg        pause_s1;
    reg        pause_s2;
    reg        pause_s3;
    wire       acc;
    wire       wr_en;
    wire       half_tick;
    wire       rise_tick;
    wire       pause_done_rise;

    // Access phase of a new APB transfer
    assign acc   = psel & penable & ~pready;
    assign wr_en = acc & pwrite;
    // MDC half-period tick and the rising half of it
    assign half_tick = (div_cnt == HALF_LAST);
    assign rise_tick = half_tick & ~mdc;
    // Edge of the synced frame-sent pulse
    assign pause_done_rise = pause_s2 & ~pause_s3;

    // Synchronisers for the data pin and the frame-sent pulse
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Synchronisers start low
            mdio_s1  <= 1'b0;
            mdio_s2  <= 1'b0;
            pause_s1 <= 1'b0;
            pause_s2 <= 1'b0;
            pause_s3 <= 1'b0;
        end
        else
        begin
            // Data pin, two flops
            mdio_s1  <= mdio_in;
            mdio_s2  <= mdio_s1;
            // Frame-sent pulse, third flop for the edge
            pause_s1 <= pause_done;
            pause_s2 <= pause_s1;
            pause_s3 <= pause_s2;
        end
    end

    // APB slave: one wait state, then pready with read data
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Bus outputs idle low
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            // Answer one cycle after the access phase
            pready  <= acc;
            // Defaults: no data, no error
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            // Read decode; unmapped offsets answer with an error
            if (acc)
            begin
                if (paddr == `MPM_ADDR_CTRL_OFS)
                begin
                    prdata <= {16'h0000, phy_select_field, phy_reg_index_field,
                               4'h0, mgmt_write_select, mgmt_busy_flag};
                end
                else if (paddr == `MPM_DATA_OFS)
                begin
                    prdata <= {16'h0000, mgmt_data_field};
                end
                else if (paddr == `MPM_FLOW_CTRL_OFS)
                begin
                    prdata <= {pause_time, 14'h0000, pause_honor, pause_send_request};
                end
                else
                begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // Control fields and pause request
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Documented reset values
            phy_select_field    <= `MPM_PHY_SEL_RST;
            phy_reg_index_field <= `MPM_REG_IDX_RST;
            mgmt_write_select   <= 1'b0;
            pause_time          <= `MPM_PAUSE_RST;
            pause_honor         <= `MPM_HONOR_RST;
            pause_send_request  <= 1'b0;
            pause_start         <= 1'b0;
        end
        else
        begin
            // Start pulse lasts one cycle
            pause_start <= 1'b0;
            // Command fields frozen while a frame runs
            if (wr_en && paddr == `MPM_ADDR_CTRL_OFS && !mgmt_busy_flag)
            begin
                phy_select_field    <= pwdata[`MPM_PHY_SEL_HI:`MPM_PHY_SEL_LO];
                phy_reg_index_field <= pwdata[`MPM_REG_IDX_HI:`MPM_REG_IDX_LO];
                mgmt_write_select   <= pwdata[`MPM_WRITE_SEL_BIT];
            end
            // Pause time and flow enable
            if (wr_en && paddr == `MPM_FLOW_CTRL_OFS)
            begin
                pause_time  <= pwdata[`MPM_PAUSE_HI:`MPM_PAUSE_LO];
                pause_honor <= pwdata[`MPM_HONOR_BIT];
            end
            // Request set only when idle; completion clears it
            if (wr_en && paddr == `MPM_FLOW_CTRL_OFS && pwdata[`MPM_SEND_BIT]
                && !pause_send_request)
            begin
                pause_send_request <= 1'b1;
                pause_start        <= 1'b1;
            end
            // Transmitter reports the frame sent
            else if (pause_done_rise)
            begin
                pause_send_request <= 1'b0;
            end
        end
    end

    // Management frame engine: MDC divider, shifter, busy flag
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state           <= ST_IDLE;
            mgmt_busy_flag  <= 1'b0;
            mgmt_data_field <= 16'h0000;
            div_cnt         <= 8'h00;
            bit_cnt         <= 7'h00;
            shifter         <= 64'h0;
            rd_shift        <= 16'h0000;
            mdc             <= 1'b0;
            // Pin released, line idles high
            mdio_out        <= 1'b1;
            mdio_oe_n       <= 1'b1;
        end
        else
        begin
            case (state)
                // Idle: MDC parked low, wait for a start request
                ST_IDLE:
                begin
                    mdc       <= 1'b0;
                    div_cnt   <= 8'h00;
                    mdio_oe_n <= 1'b1;
                    // Data latched only between frames
                    if (wr_en && paddr == `MPM_DATA_OFS && !mgmt_busy_flag)
                    begin
                        mgmt_data_field <= pwdata[15:0];
                    end
                    // Starts while busy are dropped; software polls first
                    if (wr_en && paddr == `MPM_ADDR_CTRL_OFS && !mgmt_busy_flag
                        && pwdata[`MPM_BUSY_BIT])
                    begin
                        // Preamble, start, opcode, addresses, turnaround, data.
                        // Bit 0 (a preamble one) goes out on the pin now, so the
                        // shifter holds bits 1 to 63 and the first rising MDC
                        // edge already samples a frame bit.
                        shifter <= {31'h7fff_ffff, 2'b01,
                                    pwdata[`MPM_WRITE_SEL_BIT] ? 2'b01 : 2'b10,
                                    pwdata[`MPM_PHY_SEL_HI:`MPM_PHY_SEL_LO],
                                    pwdata[`MPM_REG_IDX_HI:`MPM_REG_IDX_LO],
                                    2'b10, mgmt_data_field, 1'b0};
                        // Busy rises and the pin is driven from here
                        bit_cnt        <= 7'h00;
                        mgmt_busy_flag <= 1'b1;
                        mdio_oe_n      <= 1'b0;
                        mdio_out       <= 1'b1;
                        state          <= ST_RUN;
                    end
                end
                // Run: free-running divider, one frame bit per MDC period
                ST_RUN:
                begin
                    div_cnt <= half_tick ? 8'h00 : div_cnt + 8'h01;
                    if (half_tick)
                    begin
                        mdc <= ~mdc;
                        // Drive on falling edge, sample just before rising
                        if (mdc)
                        begin
                            // Last bit sampled: release the pin and finish
                            if (bit_cnt == LAST_BIT)
                            begin
                                mdio_oe_n <= 1'b1;
                                state     <= ST_DONE;
                            end
                            else
                            begin
                                // Next frame bit onto the pin
                                mdio_out <= shifter[63];
                                shifter  <= {shifter[62:0], 1'b0};
                                if (!mgmt_write_select && bit_cnt >= TA_FIRST)
                                begin
                                    mdio_oe_n <= 1'b1; // Release for read turnaround
                                end
                            end
                        end
                    end
                    // Count rising edges; read data taken from the synced pin
                    if (rise_tick)
                    begin
                        bit_cnt <= bit_cnt + 7'h01;
                        if (bit_cnt >= RD_FIRST)
                        begin
                            rd_shift <= {rd_shift[14:0], mdio_s2};
                        end
                    end
                end
                // Done: read result lands as busy clears
                ST_DONE:
                begin
                    if (!mgmt_write_select)
                    begin
                        mgmt_data_field <= rd_shift;
                    end
                    mgmt_busy_flag <= 1'b0;
                    mdc            <= 1'b0;
                    state          <= ST_IDLE;
                end
                // Unused codes fall back to idle
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== sim/mpm_checker.sv ====
// Port-level assertions for the PHY management block
`default_nettype none
module mpm_checker
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        mdc,
    input wire logic        mdio_out,
    input wire logic        mdio_oe_n,
    input wire logic        pause_start,
    input wire logic [15:0] pause_time,
    input wire logic        pause_honor
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Decoded bus helpers
    wire logic wr_flow = psel && penable && pwrite && paddr == 12'h01c;
    wire logic mapped  = paddr == 12'h014 || paddr == 12'h018 || paddr == 12'h01c;
    chk_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late after access");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address decode");
    chk_mdc_high_hold: assert property ($rose(mdc) |-> mdc[*8])
        else $error("mdc high phase too short");
    chk_mdc_low_hold: assert property ($fell(mdc) |-> !mdc[*8])
        else $error("mdc low phase too short");
    chk_mdio_data_edge: assert property ($changed(mdio_out) |-> !mdc)
        else $error("mdio data moved while mdc high");
    chk_mdio_oe_edge: assert property ($changed(mdio_oe_n) |-> !mdc)
        else $error("mdio enable moved while mdc high");
    chk_pause_pulse: assert property (pause_start |=> !pause_start)
        else $error("pause start longer than one cycle");
    chk_pause_cause: assert property ($rose(pause_start) |-> $past(psel && pwrite && paddr == 12'h01c))
        else $error("pause start without flow control write");
    chk_time_cause: assert property ($changed(pause_time) |-> $past(wr_flow))
        else $error("pause time changed without write");
    chk_honor_cause: assert property ($changed(pause_honor) |-> $past(wr_flow))
        else $error("flow enable changed without write");
endmodule
bind mpm_mgmt mpm_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .mdc(mdc),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .pause_start(pause_start),
    .pause_time(pause_time), .pause_honor(pause_honor));
`default_nettype wire

// ==== sim/mpm_phy_model.sv ====
// Behavioural PHY at the far end of the management bus
`default_nettype none
module mpm_phy_model
(
    input  wire logic        mdc,
    input  wire logic        mdio,
    input  wire logic [15:0] rd_value,
    output logic             drive,
    output logic             drive_bit,
    output logic [63:0]      frame
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt     = 0;
    logic is_read = 1'b0;
    logic drv_q   = 1'b0;
    // Shift in each bit on the rising clock, 64 bits a frame
    always @(posedge mdc)
    begin
        frame <= {frame[62:0], mdio};
        cnt <= (cnt == 63) ? 0 : cnt + 1;
        if (cnt == 35)
            is_read <= ({frame[0], mdio} == 2'b10);
    end
    // Turnaround zero then read data, moved after the falling clock
    always @(negedge mdc)
    begin
        drv_q <= is_read && cnt >= 47;
        drive_bit <= (cnt == 47) ? 1'b0 : rd_value[(63 - cnt) & 15];
    end
    // Let go right after the last data bit
    assign drive = drv_q && cnt != 0;
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the PHY management block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pause_done = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, mdc, mdio_out, mdio_oe_n, pause_start, pause_honor, e, w;
    logic        drive, drive_bit;
    logic [15:0] pause_time, d, rd_value = 16'h0;
    logic [63:0] frame;
    logic [4:0]  phy, ridx;
    int          num_errors = 0, cmp_count = 0, starts = 0, n;
    // Wire level with the pull-up when nobody drives
    wire logic   mdio_in = !mdio_oe_n ? mdio_out : (drive ? drive_bit : 1'b1);
    always #5 pclk = ~pclk;
    always @(posedge pclk) if (pause_start === 1'b1) starts++;
    mpm_mgmt DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
        .mdio_in(mdio_in), .pause_start(pause_start), .pause_time(pause_time),
        .pause_honor(pause_honor), .pause_done(pause_done));
    mpm_phy_model phy_m (.mdc(mdc), .mdio(mdio_in), .rd_value(rd_value), .drive(drive),
        .drive_bit(drive_bit), .frame(frame));
    // Verdict and end of run
    task automatic conclude();
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Value comparison
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, result left in r and e
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20)
        begin
            num_errors++;
            conclude();
        end
    endtask
    // Main sequence
    initial
    begin
        void'($urandom(32'h9a1b));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h014, 0); cmp(r, 32'h0000_5ac0);
        apb(0, 12'h018, 0); cmp(r, 32'h0);
        apb(0, 12'h01c, 0); cmp(r, 32'h0050_0002);
        apb(0, 12'h020, 0); cmp({r[31:1], e}, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            w = i[0];
            phy = 5'($urandom);
            ridx = 5'($urandom);
            d = 16'($urandom);
            rd_value <= 16'($urandom);
            apb(1, 12'h018, {16'h0, d});
            apb(1, 12'h014, {16'h0, phy, ridx, 4'h0, w, 1'b1});
            apb(0, 12'h014, 0); cmp({31'h0, r[0]}, 32'h1);
            n = 0;
            while (r[0] !== 1'b0 && n < 1000)
            begin
                apb(0, 12'h014, 0);
                n++;
            end
            cmp(n < 1000, 1);
            if (n >= 1000)
                conclude();
            cmp(r, {16'h0, phy, ridx, 4'h0, w, 1'b0});
            cmp(frame[63:32], 32'hffff_ffff);
            cmp(frame[31:0], {2'b01, w ? 2'b01 : 2'b10, phy, ridx, 2'b10, w ? d : rd_value});
            apb(0, 12'h018, 0); cmp(r, {16'h0, w ? d : rd_value});
        end
        d = 16'($urandom);
        apb(1, 12'h01c, {d, 16'h0001});
        repeat (2) @(posedge pclk);
        cmp(starts, 1);
        cmp({pause_honor, pause_time}, {1'b0, d});
        apb(0, 12'h01c, 0); cmp(r, {d, 16'h0001});
        pause_done <= 1'b1;
        repeat (5) @(posedge pclk);
        pause_done <= 1'b0;
        repeat (5) @(posedge pclk);
        apb(0, 12'h01c, 0); cmp(r, {d, 16'h0000});
        conclude();
    end
endmodule
`default_nettype wire
